// File: rtl/mode_sense_pkg.sv
// Constants, types and register map of the mode sense responder
package mode_sense_pkg;

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------
  localparam logic [7:0] OPC_MODE_SENSE = 8'h1a;
  localparam logic [5:0] PAGE_ALL       = 6'h3f;

  typedef enum logic [1:0] {
    PC_CURRENT = 2'b00,
    PC_CHANGE  = 2'b01,
    PC_DEFAULT = 2'b10,
    PC_SAVED   = 2'b11
  } pc_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] unit_byte;
    logic [1:0] page_control_field;
    logic [5:0] page_code;
    logic [7:0] rsvd_byte;
    logic [7:0] alloc_len;
    logic [7:0] control;
  } cdb_s;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } din_s;

  // ------------------------------------------------------------------
  // Pages: ascending order, page 00h last
  // ------------------------------------------------------------------
  localparam int              NUM_PAGES  = 12;
  localparam logic [3:0]      LAST_PAGE  = 4'd11;
  localparam logic [11:0][5:0] PAGE_CODES = {6'h00, 6'h39, 6'h38, 6'h37, 6'h32, 6'h0c,
                                            6'h0a, 6'h08, 6'h04, 6'h03, 6'h02, 6'h01};
  localparam int              PAGE_BODY  = 6;
  localparam logic [7:0]      PAGE_LEN   = 8'h06;
  localparam logic [7:0]      DESC_BYTES = 8'h08;

  // ------------------------------------------------------------------
  // Header and block descriptor
  // ------------------------------------------------------------------
  localparam logic [7:0]  HDR_BYTES    = 8'h04;
  localparam logic [7:0]  BD_END       = 8'h0c;
  localparam logic [7:0]  BD_LEN       = 8'h08;
  localparam logic [23:0] BLOCK_COUNT  = 24'h000000;
  localparam logic [23:0] BLOCK_LEN    = 24'h000200;

  // ------------------------------------------------------------------
  // Page value banks
  // ------------------------------------------------------------------
  localparam logic [1:0] BANK_CURRENT = 2'd0;
  localparam logic [1:0] BANK_CHANGE  = 2'd1;
  localparam logic [1:0] BANK_DEFAULT = 2'd2;
  localparam logic [1:0] BANK_SAVED   = 2'd3;
  localparam int         BANK_SIZE    = NUM_PAGES * PAGE_BODY;
  localparam int         MEM_DEPTH    = 4 * BANK_SIZE;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [4:0] REG_CMD_LO    = 5'h00;
  localparam logic [4:0] REG_CMD_HI    = 5'h04;
  localparam logic [4:0] REG_CTRL      = 5'h08;
  localparam logic [4:0] REG_STATUS    = 5'h0c;
  localparam logic [4:0] REG_PAGE_ADDR = 5'h10;
  localparam logic [4:0] REG_PAGE_DATA = 5'h14;

  localparam int CTRL_START       = 0;
  localparam int CTRL_SELECT_DONE = 1;
  localparam int CTRL_SAVE_DONE   = 2;
  localparam int CTRL_CLEAR_DONE  = 3;

  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_CHECK     = 2;
  localparam int ST_CUR_VALID = 3;
  localparam int ST_SAV_VALID = 4;
  localparam int ST_COUNT_LSB = 8;

endpackage

// File: rtl/mode_sense_responder.sv
// Mode sense command handler: decode, response build and data-in stream
//
// How it works
// RULE1: Opcode 1Ah starts a mode sense
// RULE2: Byte 2 bits 7-6 pick value set
// RULE3: Current values, else saved before any select
// RULE4: Changeable: modifiable bits one, others zero
// RULE5: Default: factory values, unsupported bits zero
// RULE6: Saved values, else default before any save
// RULE7: Page length field gives supported byte count
// RULE8: Byte 2 bits 5-0 pick supported page
// RULE9: Code 3Fh: all pages ascending, 00h last
// RULE10: Send minimum of allocation and available bytes
// RULE11: Header, block descriptor, then page descriptors
// RULE12: Header byte 0 counts bytes after itself
// RULE13: Medium type and protect/cache bits read zero
// RULE14: Block descriptor length reads 08h
// RULE15: Descriptor: zero, 24-bit count, zero, 24-bit length
// RULE16: Block count zero covers all remaining blocks
// RULE17: Block length reads 200h
// RULE18: Page byte 0: saveable, zero, page code
// RULE19: Initiator keeps unit, DB, control bits zero
// RULE20: Saveable bit set on pages it can save
// RULE21: Unsupported page: check condition, no data
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/10ps

module mode_sense_responder (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Data-in byte stream toward the initiator
  output logic      [7:0]  DIN_DATA,
  output logic             DIN_VALID,
  output logic             DIN_LAST,
  input  wire logic        DIN_READY,
  // Command completion
  output logic             CMD_DONE,
  output logic             CMD_CHECK
);

  // ------------------------------------------------------------------
  // Types and functions
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_DECODE = 2'b01,
    S_SEND   = 2'b10,
    S_FINISH = 2'b11
  } state_e;

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [8:0] mem_index(input logic [1:0] bank,
                                           input logic [3:0] page,
                                           input logic [2:0] offs);
    logic [15:0] r;
    r = 16'(bank) * 16'(mode_sense_pkg::BANK_SIZE)
      + 16'(page) * 16'(mode_sense_pkg::PAGE_BODY) + 16'(offs);
    return r[8:0];
  endfunction

  // Single requests never hit 00h; it is only sent as part of 3Fh
  function automatic logic [4:0] find_page(input logic [5:0] code);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < mode_sense_pkg::NUM_PAGES - 1; i++) begin
      if (mode_sense_pkg::PAGE_CODES[i] == code) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  state_e                   state_r;
  mode_sense_pkg::cdb_s     cmd_r;
  mode_sense_pkg::din_s     din_r;
  logic                     din_valid_r;
  logic        [7:0]        mem_r [0:mode_sense_pkg::MEM_DEPTH-1];
  logic        [8:0]        page_addr_r;
  logic                     cur_valid_r;
  logic                     sav_valid_r;
  logic                     done_r;
  logic                     check_r;
  logic                     cmd_done_r;
  logic                     all_r;
  logic        [3:0]        sel_page_r;
  logic        [1:0]        bank_r;
  logic        [7:0]        total_r;
  logic        [7:0]        send_len_r;
  logic        [7:0]        pos_r;
  logic                     ack_r;
  logic        [31:0]       rdata_r;

  logic                     bus_req;
  logic                     wr_take;
  logic                     start_req;
  logic        [4:0]        hit;
  logic        [7:0]        avail;
  logic        [7:0]        resp_byte;
  logic        [11:0]       saveable;

  // ------------------------------------------------------------------
  // Avalon slave handshake: one wait state on every access
  // ------------------------------------------------------------------
  assign bus_req         = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = bus_req & ~ack_r;
  assign AVS_READDATA    = rdata_r;
  assign wr_take         = AVS_WRITE & ack_r;
  assign start_req       = wr_take && AVS_ADDRESS == mode_sense_pkg::REG_CTRL
                           && AVS_BYTEENABLE[0] && AVS_WRITEDATA[mode_sense_pkg::CTRL_START];

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  // Read data captured in the wait cycle, stands at the answering edge
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_r <= 32'h00000000;
    end else if (AVS_READ && !ack_r) begin
      case (AVS_ADDRESS)
        mode_sense_pkg::REG_CMD_LO:    rdata_r <= cmd_r[47:16];
        mode_sense_pkg::REG_CMD_HI:    rdata_r <= {16'h0000, cmd_r[15:0]};
        mode_sense_pkg::REG_STATUS: begin
          rdata_r                                      <= 32'h00000000;
          rdata_r[mode_sense_pkg::ST_BUSY]             <= state_r != S_IDLE;
          rdata_r[mode_sense_pkg::ST_DONE]             <= done_r;
          rdata_r[mode_sense_pkg::ST_CHECK]            <= check_r;
          rdata_r[mode_sense_pkg::ST_CUR_VALID]        <= cur_valid_r;
          rdata_r[mode_sense_pkg::ST_SAV_VALID]        <= sav_valid_r;
          rdata_r[mode_sense_pkg::ST_COUNT_LSB +: 8]   <= pos_r;
        end
        mode_sense_pkg::REG_PAGE_ADDR: rdata_r <= {23'h000000, page_addr_r};
        mode_sense_pkg::REG_PAGE_DATA: rdata_r <= {24'h000000,
            mem_r[mem_index(page_addr_r[8:7], page_addr_r[6:3], page_addr_r[2:0])]};
        default:                       rdata_r <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  // Command block only loads while idle so a running transfer is stable
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cmd_r <= '0;
    end else if (wr_take && state_r == S_IDLE) begin
      if (AVS_ADDRESS == mode_sense_pkg::REG_CMD_LO) begin
        cmd_r[47:16] <= merge_be(cmd_r[47:16], AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == mode_sense_pkg::REG_CMD_HI) begin
        cmd_r[15:0] <= 16'(merge_be({16'h0000, cmd_r[15:0]}, AVS_WRITEDATA,
                                    {2'b00, AVS_BYTEENABLE[1:0]}));
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      page_addr_r <= 9'h000;
    end else if (wr_take && AVS_ADDRESS == mode_sense_pkg::REG_PAGE_ADDR) begin
      page_addr_r <= 9'(merge_be({23'h000000, page_addr_r}, AVS_WRITEDATA, AVS_BYTEENABLE));
    end
  end

  // Bank contents start at zero, so unloaded default bits read zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < mode_sense_pkg::MEM_DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (wr_take && AVS_ADDRESS == mode_sense_pkg::REG_PAGE_DATA && AVS_BYTEENABLE[0]
                 && page_addr_r[6:3] <= mode_sense_pkg::LAST_PAGE
                 && 32'(page_addr_r[2:0]) < mode_sense_pkg::PAGE_BODY) begin
      mem_r[mem_index(page_addr_r[8:7], page_addr_r[6:3], page_addr_r[2:0])] <=
        AVS_WRITEDATA[7:0];
    end
  end

  // Firmware reports completed mode selects; cleared only by reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cur_valid_r <= 1'b0;
      sav_valid_r <= 1'b0;
    end else if (wr_take && AVS_ADDRESS == mode_sense_pkg::REG_CTRL && AVS_BYTEENABLE[0]) begin
      if (AVS_WRITEDATA[mode_sense_pkg::CTRL_SELECT_DONE]) begin
        cur_valid_r <= 1'b1;
      end
      if (AVS_WRITEDATA[mode_sense_pkg::CTRL_SAVE_DONE]) begin
        sav_valid_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  assign hit = find_page(cmd_r.page_code); // RULE8

  // Pages with any initiator-modifiable bit are the saveable ones
  always_comb begin
    saveable = 12'h000;
    for (int p = 0; p < mode_sense_pkg::NUM_PAGES; p++) begin
      for (int b = 0; b < mode_sense_pkg::PAGE_BODY; b++) begin
        if (mem_r[mem_index(mode_sense_pkg::BANK_CHANGE, 4'(p), 3'(b))] != 8'h00) begin
          saveable[p] = 1'b1; // RULE20
        end
      end
    end
  end

  always_comb begin
    if (cmd_r.page_code == mode_sense_pkg::PAGE_ALL) begin
      avail = mode_sense_pkg::BD_END
            + 8'(mode_sense_pkg::NUM_PAGES) * mode_sense_pkg::DESC_BYTES; // RULE9
    end else begin
      avail = mode_sense_pkg::BD_END + mode_sense_pkg::DESC_BYTES;
    end
  end

  // ------------------------------------------------------------------
  // Response byte at position pos_r
  // ------------------------------------------------------------------
  always_comb begin
    logic [7:0] rel;
    logic [3:0] pg;
    rel       = pos_r - mode_sense_pkg::BD_END;
    pg        = all_r ? rel[6:3] : sel_page_r;
    resp_byte = 8'h00;
    if (pos_r < mode_sense_pkg::HDR_BYTES) begin // RULE11
      case (pos_r[1:0])
        2'd0:    resp_byte = total_r - 8'h01; // RULE12
        2'd3:    resp_byte = mode_sense_pkg::BD_LEN; // RULE14
        default: resp_byte = 8'h00; // RULE13
      endcase
    end else if (pos_r < mode_sense_pkg::BD_END) begin // RULE15
      case (pos_r[3:0])
        4'd5:    resp_byte = mode_sense_pkg::BLOCK_COUNT[23:16]; // RULE16
        4'd6:    resp_byte = mode_sense_pkg::BLOCK_COUNT[15:8];
        4'd7:    resp_byte = mode_sense_pkg::BLOCK_COUNT[7:0];
        4'd9:    resp_byte = mode_sense_pkg::BLOCK_LEN[23:16]; // RULE17
        4'd10:   resp_byte = mode_sense_pkg::BLOCK_LEN[15:8];
        4'd11:   resp_byte = mode_sense_pkg::BLOCK_LEN[7:0];
        default: resp_byte = 8'h00;
      endcase
    end else begin
      case (rel[2:0])
        3'd0:    resp_byte = {saveable[pg], 1'b0, mode_sense_pkg::PAGE_CODES[pg]}; // RULE18
        3'd1:    resp_byte = mode_sense_pkg::PAGE_LEN; // RULE7
        default: resp_byte = mem_r[mem_index(bank_r, pg, rel[2:0] - 3'd2)];
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r     <= S_IDLE;
      all_r       <= 1'b0;
      sel_page_r  <= 4'h0;
      bank_r      <= mode_sense_pkg::BANK_SAVED;
      total_r     <= 8'h00;
      send_len_r  <= 8'h00;
      pos_r       <= 8'h00;
      din_r       <= '0;
      din_valid_r <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (start_req) begin
            state_r <= S_DECODE;
            pos_r   <= 8'h00;
          end
        end
        S_DECODE: begin
          all_r      <= cmd_r.page_code == mode_sense_pkg::PAGE_ALL;
          sel_page_r <= hit[3:0];
          total_r    <= avail;
          send_len_r <= (cmd_r.alloc_len < avail) ? cmd_r.alloc_len : avail; // RULE10
          case (mode_sense_pkg::pc_e'(cmd_r.page_control_field)) // RULE2
            mode_sense_pkg::PC_CURRENT: bank_r <= cur_valid_r ? mode_sense_pkg::BANK_CURRENT
                                        : sav_valid_r ? mode_sense_pkg::BANK_SAVED
                                        : mode_sense_pkg::BANK_DEFAULT; // RULE3
            mode_sense_pkg::PC_CHANGE:  bank_r <= mode_sense_pkg::BANK_CHANGE; // RULE4
            mode_sense_pkg::PC_DEFAULT: bank_r <= mode_sense_pkg::BANK_DEFAULT; // RULE5
            default:                    bank_r <= sav_valid_r ? mode_sense_pkg::BANK_SAVED
                                                  : mode_sense_pkg::BANK_DEFAULT; // RULE6
          endcase
          if (cmd_r.opcode != mode_sense_pkg::OPC_MODE_SENSE // RULE1
              || (cmd_r.page_code != mode_sense_pkg::PAGE_ALL && !hit[4])) begin
            state_r <= S_FINISH; // RULE21
          end else begin
            state_r <= S_SEND;
          end
        end
        S_SEND: begin
          if (!din_valid_r || DIN_READY) begin
            if (pos_r != send_len_r) begin
              din_r.data  <= resp_byte;
              din_r.last  <= pos_r == send_len_r - 8'h01;
              din_valid_r <= 1'b1;
              pos_r       <= pos_r + 8'h01;
            end else begin
              din_valid_r <= 1'b0;
              din_r.last  <= 1'b0;
              state_r     <= S_FINISH;
            end
          end
        end
        S_FINISH: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Completion status; a finishing command wins over a software clear
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      done_r     <= 1'b0;
      check_r    <= 1'b0;
      cmd_done_r <= 1'b0;
    end else begin
      cmd_done_r <= state_r == S_FINISH;
      if (state_r == S_DECODE) begin
        check_r <= cmd_r.opcode != mode_sense_pkg::OPC_MODE_SENSE
                   || (cmd_r.page_code != mode_sense_pkg::PAGE_ALL && !hit[4]); // RULE21
      end
      if (state_r == S_FINISH) begin
        done_r <= 1'b1;
      end else if (wr_take && AVS_ADDRESS == mode_sense_pkg::REG_CTRL && AVS_BYTEENABLE[0]
                   && AVS_WRITEDATA[mode_sense_pkg::CTRL_CLEAR_DONE]) begin
        done_r <= 1'b0;
      end
    end
  end

  assign DIN_DATA  = din_r.data;
  assign DIN_LAST  = din_r.last;
  assign DIN_VALID = din_valid_r;
  assign CMD_DONE  = cmd_done_r;
  assign CMD_CHECK = check_r;

endmodule

// File: bench/mode_sense_checker_assertions.sv
// Port-level property checker for the mode sense responder
`timescale 1ns/10ps

module mode_sense_checker (
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       RST,
  // Register bus
  input wire logic       AVS_READ,
  input wire logic       AVS_WRITE,
  input wire logic       AVS_WAITREQUEST,
  // Data-in stream and completion
  input wire logic [7:0] DIN_DATA,
  input wire logic       DIN_VALID,
  input wire logic       DIN_LAST,
  input wire logic       DIN_READY,
  input wire logic       CMD_DONE,
  input wire logic       CMD_CHECK
);
  logic [7:0] idx_r;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // Byte position in the response, restarted at each completion
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      idx_r <= 8'h00;
    end else if (CMD_DONE) begin
      idx_r <= 8'h00;
    end else if (DIN_VALID && DIN_READY) begin
      idx_r <= idx_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  wait_one_a: assert property ($rose(AVS_READ || AVS_WRITE) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("bus answer not after one wait");
  hold_a: assert property (DIN_VALID && !DIN_READY |=> DIN_VALID &&
    $stable(DIN_DATA) && $stable(DIN_LAST)) else $error("stalled byte changed");
  len_byte_a: assert property (DIN_VALID && idx_r == 8'h00 |->
    DIN_DATA inside {8'h13, 8'h6b}) else $error("mode data length wrong");
  hdr_zero_a: assert property (DIN_VALID && idx_r inside {8'h01, 8'h02} |->
    DIN_DATA == 8'h00) else $error("medium or protect byte not zero");
  bd_len_a: assert property (DIN_VALID && idx_r == 8'h03 |->
    DIN_DATA == 8'h08) else $error("descriptor length wrong");
  bd_zero_a: assert property (DIN_VALID && idx_r inside {[8'h04:8'h09], 8'h0b} |->
    DIN_DATA == 8'h00) else $error("descriptor zero byte wrong");
  blk_len_a: assert property (DIN_VALID && idx_r == 8'h0a |->
    DIN_DATA == 8'h02) else $error("block length wrong");
  pg_len_a: assert property (DIN_VALID && idx_r >= 8'h0c && idx_r[2:0] == 3'h5 |->
    DIN_DATA == 8'h06) else $error("page length wrong");
  pg_code_a: assert property (DIN_VALID && idx_r >= 8'h0c && idx_r[2:0] == 3'h4 |->
    !DIN_DATA[6]) else $error("page header reserved bit set");
  last_done_a: assert property (DIN_VALID && DIN_READY && DIN_LAST |=>
    !DIN_VALID ##[1:2] CMD_DONE) else $error("no completion after last byte");
  check_nodata_a: assert property (CMD_CHECK |-> !DIN_VALID)
    else $error("data sent on check condition");

  c_last: cover property (DIN_VALID && DIN_READY && DIN_LAST);
  c_stall: cover property (DIN_VALID && !DIN_READY);
  c_check: cover property (CMD_DONE && CMD_CHECK);
endmodule

bind mode_sense_responder mode_sense_checker u_chk (
  .MCLK            (MCLK),
  .RST             (RST),
  .AVS_READ        (AVS_READ),
  .AVS_WRITE       (AVS_WRITE),
  .AVS_WAITREQUEST (AVS_WAITREQUEST),
  .DIN_DATA        (DIN_DATA),
  .DIN_VALID       (DIN_VALID),
  .DIN_LAST        (DIN_LAST),
  .DIN_READY       (DIN_READY),
  .CMD_DONE        (CMD_DONE),
  .CMD_CHECK       (CMD_CHECK)
);

// File: bench/din_sink.sv
// Initiator-side model that accepts the data-in stream
`timescale 1ns/10ps

module din_sink (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST,
  // Data-in stream
  input  wire logic [7:0] DIN_DATA,
  input  wire logic       DIN_VALID,
  input  wire logic       DIN_LAST,
  output logic            DIN_READY,
  // Bench control
  input  wire logic       stall
);
  logic [7:0] rx [0:255];
  int         rx_n;
  int         tot;
  logic       open_r;
  logic [2:0] ph_r;

  // Irregular stalls exercise the hold path
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ph_r      <= 3'h0;
      DIN_READY <= 1'b0;
    end else begin
      ph_r      <= ph_r + 3'h1;
      DIN_READY <= !stall || ph_r[0] || ph_r[2];
    end
  end

  // A frame restarts after a byte marked last
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rx_n   <= 0;
      tot    <= 0;
      open_r <= 1'b0;
    end else if (DIN_VALID && DIN_READY) begin
      rx_n   <= open_r ? rx_n + 1 : 1;
      tot    <= tot + 1;
      open_r <= !DIN_LAST;
    end
  end

  always_ff @(posedge MCLK) begin
    if (DIN_VALID && DIN_READY) begin
      rx[open_r ? rx_n[7:0] : 8'h00] <= DIN_DATA;
    end
  end
endmodule

// File: bench/mode_sense_responder_test.sv
// Self-checking bench for the mode sense responder
`timescale 1ns/10ps

module mode_sense_responder_test;
  logic        MCLK;
  logic        RST;
  logic [4:0]  AVS_ADDRESS;
  logic        AVS_READ;
  logic        AVS_WRITE;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic [7:0]  DIN_DATA;
  logic        DIN_VALID;
  logic        DIN_LAST;
  logic        DIN_READY;
  logic        CMD_DONE;
  logic        CMD_CHECK;
  logic        stall;
  logic [31:0] rd;
  int          fails;
  int          compares;
  logic [7:0]  codes [0:11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0a,
                                8'h0c, 8'h32, 8'h37, 8'h38, 8'h39, 8'h00};
  logic [7:0]  hdr [0:11] = '{8'h13, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00,
                              8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};

  mode_sense_responder u_dut (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .DIN_DATA(DIN_DATA), .DIN_VALID(DIN_VALID),
    .DIN_LAST(DIN_LAST), .DIN_READY(DIN_READY), .CMD_DONE(CMD_DONE),
    .CMD_CHECK(CMD_CHECK));
  din_sink u_sink (.MCLK(MCLK), .RST(RST), .DIN_DATA(DIN_DATA), .DIN_VALID(DIN_VALID),
    .DIN_LAST(DIN_LAST), .DIN_READY(DIN_READY), .stall(stall));

  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until waitrequest is seen low; settled values read mid-cycle
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    int   n    = 0;
    logic busy = 1'b1;
    @(posedge MCLK);
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    AVS_WRITEDATA <= d;
    while (busy && n < 20) begin
      @(negedge MCLK);
      busy = AVS_WAITREQUEST !== 1'b0;
      rd   = AVS_READDATA;
      @(posedge MCLK);
      n++;
    end
    if (busy) fails++;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task automatic run(input logic [7:0] opc, input logic [7:0] pcc, input logic [7:0] len);
    int n;
    n = 0;
    bus(mode_sense_pkg::REG_CMD_LO, 1'b1, {opc, 8'h00, pcc, 8'h00});
    bus(mode_sense_pkg::REG_CMD_HI, 1'b1, {16'h0000, len, 8'h00});
    bus(mode_sense_pkg::REG_CTRL, 1'b1, 32'h0000_0001);
    while (CMD_DONE !== 1'b1 && n < 2000) begin
      @(negedge MCLK);
      n++;
    end
    if (CMD_DONE !== 1'b1) fails++;
  endtask

  task automatic sense(input logic [1:0] pc, input logic [7:0] exp);
    run(8'h1a, {pc, 6'h01}, 8'hff);
    chk("count", 20, u_sink.rx_n);
    chk("body", exp, u_sink.rx[14]);
    chk("page head", 8'h81, u_sink.rx[12]);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    bus(5'h18, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(mode_sense_pkg::REG_CMD_HI, 1'b1, 32'hffff_ff00);
    bus(mode_sense_pkg::REG_CMD_HI, 1'b0, 32'h0);
    chk("cmd hi", 32'h0000_ff00, rd);
    $display("test regs done");
  endtask

  // Page 01h body byte 0 differs per bank, so the set chosen is visible
  task automatic t_sets;
    for (int b = 0; b < 4; b++) begin
      bus(mode_sense_pkg::REG_PAGE_ADDR, 1'b1, {23'h0, b[1:0], 4'h0, 3'h0});
      bus(mode_sense_pkg::REG_PAGE_DATA, 1'b1, {24'h0, 6'h28, b[1:0]});
    end
    sense(2'b00, 8'ha2);
    for (int i = 0; i < 12; i++) chk("header", hdr[i], u_sink.rx[i]);
    chk("page len", 8'h06, u_sink.rx[13]);
    sense(2'b01, 8'ha1);
    sense(2'b10, 8'ha2);
    sense(2'b11, 8'ha2);
    bus(mode_sense_pkg::REG_CTRL, 1'b1, 32'h0000_0004);
    sense(2'b11, 8'ha3);
    sense(2'b00, 8'ha3);
    bus(mode_sense_pkg::REG_CTRL, 1'b1, 32'h0000_0002);
    sense(2'b00, 8'ha0);
    sense(2'b11, 8'ha3);
    $display("test value sets done");
  endtask

  task automatic t_all;
    stall <= 1'b1;
    run(8'h1a, 8'h3f, 8'hff);
    stall <= 1'b0;
    chk("all count", 108, u_sink.rx_n);
    chk("all length", 8'h6b, u_sink.rx[0]);
    for (int k = 0; k < 12; k++) begin
      chk("code", codes[k], {2'b00, u_sink.rx[12 + 8 * k][5:0]});
      chk("plen", 8'h06, u_sink.rx[13 + 8 * k]);
      chk("saveable", k == 0, u_sink.rx[12 + 8 * k][7]);
    end
    $display("test all pages done");
  endtask

  task automatic t_alloc;
    int t0;
    run(8'h1a, 8'h3f, 8'h05);
    chk("short count", 5, u_sink.rx_n);
    chk("short length", 8'h6b, u_sink.rx[0]);
    t0 = u_sink.tot;
    run(8'h1a, 8'h3f, 8'h00);
    chk("zero alloc", t0, u_sink.tot);
    for (int k = 0; k < 11; k++) begin
      run(8'h1a, {2'b10, codes[k][5:0]}, 8'h0e);
      chk("one code", codes[k], {2'b00, u_sink.rx[12][5:0]});
      chk("one count", 14, u_sink.rx_n);
    end
    $display("test allocation done");
  endtask

  task automatic t_bad;
    int t0;
    t0 = u_sink.tot;
    run(8'h1a, 8'h05, 8'hff);
    chk("bad page", 1'b1, CMD_CHECK);
    run(8'h12, 8'h01, 8'hff);
    chk("bad opcode", 1'b1, CMD_CHECK);
    chk("no data", t0, u_sink.tot);
    run(8'h1a, 8'h01, 8'hff);
    chk("good clears", 1'b0, CMD_CHECK);
    $display("test refusals done");
  endtask

  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole run needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge MCLK);
    fails++;
    report_and_stop();
  end

  initial begin
    RST            = 1'b1;
    stall          = 1'b0;
    AVS_ADDRESS    = 5'h00;
    AVS_READ       = 1'b0;
    AVS_WRITE      = 1'b0;
    AVS_BYTEENABLE = 4'hf;
    AVS_WRITEDATA  = 32'h0;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    t_regs();
    t_sets();
    t_all();
    t_alloc();
    t_bad();
    report_and_stop();
  end
endmodule
